// *** rtl/epwm_top.sv ***
// Eight channel PWM timer with register port and pair joining.
// Assumes a master on clk_i that issues one cycle read or write
// strobes; read data is valid only in the cycle after the strobe.
//
// Functional notes
// RULE_01: eight 8-bit channels, own counter, period, duty
// RULE_02: duty selectable from always off to on
// RULE_03: pulse density mode besides normal modulation
// RULE_04: programmable output polarity per channel
// RULE_05: left aligned wrap or center aligned up-down
// RULE_06: adjacent pairs join into 16-bit channels
// RULE_07: joining chosen per pair, any mix
// RULE_08: new period and duty apply next period
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "epwm_defs.svh"

module epwm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire epwm_pkg::epwm_addr_t addr_i,
    input wire epwm_pkg::epwm_byte_t wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output epwm_pkg::epwm_byte_t rdata_o,
    output wire logic [7:0] pwm_o
);
    import epwm_pkg::*;

    epwm_byte_t en_ff, nxt_en;
    epwm_byte_t pol_ff, nxt_pol;
    epwm_byte_t ctr_ff, nxt_ctr;
    epwm_byte_t pcm_ff, nxt_pcm;
    logic [3:0] cat_ff, nxt_cat;
    epwm_byte_t per_ff [`EPWM_NCH];
    epwm_byte_t nxt_per [`EPWM_NCH];
    epwm_byte_t duty_ff [`EPWM_NCH];
    epwm_byte_t nxt_duty [`EPWM_NCH];
    epwm_byte_t rdata_ff, nxt_rdata;
    epwm_word_t cnt_w [`EPWM_NCH];
    epwm_byte_t rd_cnt [`EPWM_NCH];

    assign rdata_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register writes and read mux
    always_comb begin
        nxt_en = en_ff;
        nxt_pol = pol_ff;
        nxt_ctr = ctr_ff;
        nxt_pcm = pcm_ff;
        nxt_cat = cat_ff;
        nxt_per = per_ff;
        nxt_duty = duty_ff;
        nxt_rdata = 8'h00;
        if (we_i) begin
            case (addr_i[5:3])
                `EPWM_PG_CTL: begin
                    case (addr_i)
                        `EPWM_A_ENABLE: begin
                            nxt_en = wdata_i;
                        end
                        `EPWM_A_POL: begin
                            nxt_pol = wdata_i; // see RULE_04
                        end
                        `EPWM_A_CTR: begin
                            nxt_ctr = wdata_i; // see RULE_05
                        end
                        `EPWM_A_CAT: begin
                            nxt_cat = wdata_i[3:0]; // see RULE_07
                        end
                        `EPWM_A_PCM: begin
                            nxt_pcm = wdata_i; // see RULE_03
                        end
                        default: begin
                        end
                    endcase
                end
                `EPWM_PG_PER: begin
                    nxt_per[addr_i[2:0]] = wdata_i; // see RULE_01
                end
                `EPWM_PG_DUTY: begin
                    nxt_duty[addr_i[2:0]] = wdata_i; // see RULE_02
                end
                default: begin
                end
            endcase
        end
        if (re_i) begin
            case (addr_i[5:3])
                `EPWM_PG_CTL: begin
                    case (addr_i)
                        `EPWM_A_ENABLE: begin
                            nxt_rdata = en_ff;
                        end
                        `EPWM_A_POL: begin
                            nxt_rdata = pol_ff;
                        end
                        `EPWM_A_CTR: begin
                            nxt_rdata = ctr_ff;
                        end
                        `EPWM_A_CAT: begin
                            nxt_rdata = {4'h0, cat_ff};
                        end
                        `EPWM_A_PCM: begin
                            nxt_rdata = pcm_ff;
                        end
                        default: begin
                            nxt_rdata = 8'h00;
                        end
                    endcase
                end
                `EPWM_PG_CNT: begin
                    nxt_rdata = rd_cnt[addr_i[2:0]];
                end
                `EPWM_PG_PER: begin
                    nxt_rdata = per_ff[addr_i[2:0]];
                end
                `EPWM_PG_DUTY: begin
                    nxt_rdata = duty_ff[addr_i[2:0]];
                end
                default: begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_ff <= `EPWM_RST_BYTE;
            pol_ff <= `EPWM_RST_BYTE;
            ctr_ff <= `EPWM_RST_BYTE;
            pcm_ff <= `EPWM_RST_BYTE;
            cat_ff <= `EPWM_RST_CAT;
            per_ff <= '{default: `EPWM_RST_PER};
            duty_ff <= '{default: `EPWM_RST_DUTY};
            rdata_ff <= 8'h00;
        end else begin
            en_ff <= nxt_en;
            pol_ff <= nxt_pol;
            ctr_ff <= nxt_ctr;
            pcm_ff <= nxt_pcm;
            cat_ff <= nxt_cat;
            per_ff <= nxt_per;
            duty_ff <= nxt_duty;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel engines; a joined pair runs on the odd engine and the
    // even engine is held off, so its pin idles at the inactive level
    for (genvar i = 0; i < `EPWM_NCH; i++) begin : g_ch
        epwm_word_t per_w;
        epwm_word_t duty_w;
        logic en_w;

        if (i % 2 == 1) begin : g_hi
            assign per_w = cat_ff[i / 2] ? // see RULE_06
                {per_ff[i], per_ff[i - 1]} : {8'h00, per_ff[i]};
            assign duty_w = cat_ff[i / 2] ?
                {duty_ff[i], duty_ff[i - 1]} : {8'h00, duty_ff[i]};
            assign en_w = en_ff[i];
            assign rd_cnt[i] = cat_ff[i / 2] ?
                cnt_w[i][15:8] : cnt_w[i][7:0];
        end else begin : g_lo
            assign per_w = {8'h00, per_ff[i]};
            assign duty_w = {8'h00, duty_ff[i]};
            assign en_w = en_ff[i] && !cat_ff[i / 2]; // see RULE_06
            assign rd_cnt[i] = cat_ff[i / 2] ?
                cnt_w[i + 1][7:0] : cnt_w[i][7:0];

            property p_pair_idle;
                @(posedge clk_i) disable iff (rst_i)
                $past(cat_ff[i / 2]) |-> pwm_o[i] == !$past(pol_ff[i]);
            endproperty
            a_pair_idle: assert property (p_pair_idle) // see RULE_06
                else $error("joined pair low pin not idle");
        end

        epwm_chan u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .en_i(en_w),
            .pol_i(pol_ff[i]),
            .ctr_i(ctr_ff[i]),
            .pcm_i(pcm_ff[i]),
            .per_i(per_w),
            .duty_i(duty_w),
            .cnt_o(cnt_w[i]),
            .pwm_o(pwm_o[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    property p_cat_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(we_i && addr_i == `EPWM_A_CAT) |=> $stable(cat_ff);
    endproperty
    a_cat_hold: assert property (p_cat_hold) // see RULE_07
        else $error("pair joining changed without a write");

    ////////////////////////////////////////////////////////////////////////
    // Register port: read data stands one cycle, writes land next edge
    property p_rdata_idle;
        @(posedge clk_i) disable iff (rst_i)
        !re_i |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // see RULE_01
        else $error("read data stood without a read strobe");

    property p_per_write;
        @(posedge clk_i) disable iff (rst_i)
        we_i && addr_i[5:3] == `EPWM_PG_PER |=>
        per_ff[$past(addr_i[2:0])] == $past(wdata_i);
    endproperty
    a_per_write: assert property (p_per_write) // see RULE_01
        else $error("period register did not take the write");

    c_mixed: cover property (@(posedge clk_i) disable iff (rst_i)
        cat_ff == 4'h5 && en_ff == 8'hff);
    c_all_wide: cover property (@(posedge clk_i) disable iff (rst_i)
        cat_ff == 4'hf && en_ff == 8'haa);

endmodule : epwm_top

// *** rtl/epwm_defs.svh ***
// Register map, reset values and sizes of the eight channel PWM timer.
// Assumes a byte wide register port with a six bit address.
`ifndef EPWM_DEFS_SVH
`define EPWM_DEFS_SVH

`define EPWM_NCH 8
`define EPWM_NPAIR 4

// Control page, one register each
`define EPWM_A_ENABLE 6'h00
`define EPWM_A_POL 6'h01
`define EPWM_A_CTR 6'h02
`define EPWM_A_CAT 6'h03
`define EPWM_A_PCM 6'h04

// Register pages, selected by address bits 5:3; the CNT, PER and DUTY pages take the channel in bits 2:0
`define EPWM_PG_CTL 3'h0
`define EPWM_PG_CNT 3'h1
`define EPWM_PG_PER 3'h2
`define EPWM_PG_DUTY 3'h3

`define EPWM_RST_BYTE 8'h00
`define EPWM_RST_CAT 4'h0
`define EPWM_RST_PER 8'hff
`define EPWM_RST_DUTY 8'h00

`endif

// *** rtl/epwm_pkg.sv ***
// Types shared by the PWM timer top and its channel engine.
// Assumes nothing of its surroundings.
package epwm_pkg;
    typedef logic [7:0] epwm_byte_t;
    typedef logic [15:0] epwm_word_t;
    typedef logic [5:0] epwm_addr_t;
    typedef enum logic {
        EPWM_UP = 1'b0,
        EPWM_DOWN = 1'b1
    } epwm_dir_t;
endpackage : epwm_pkg

// *** rtl/epwm_chan.sv ***
// One 16 bit PWM channel engine: counter, shadowed period and duty,
// left, center and pulse density modes, programmable polarity.
// Assumes all inputs are synchronous to clk_i.
`timescale 1ns/1ps

module epwm_chan (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic pol_i,
    input wire logic ctr_i,
    input wire logic pcm_i,
    input wire epwm_pkg::epwm_word_t per_i,
    input wire epwm_pkg::epwm_word_t duty_i,
    output epwm_pkg::epwm_word_t cnt_o,
    output logic pwm_o
);
    import epwm_pkg::*;

    epwm_word_t cnt_ff, nxt_cnt;
    epwm_word_t acc_ff, nxt_acc;
    epwm_word_t per_sh_ff, nxt_per_sh;
    epwm_word_t duty_sh_ff, nxt_duty_sh;
    epwm_dir_t dir_ff, nxt_dir;
    logic out_ff, nxt_out;
    logic wrap;
    logic act;
    logic [16:0] sum;

    assign cnt_o = cnt_ff;
    assign pwm_o = out_ff;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_acc = 16'h0000;
        nxt_per_sh = per_sh_ff;
        nxt_duty_sh = duty_sh_ff;
        nxt_dir = dir_ff;
        act = 1'b0;
        sum = 17'h00000;
        if (ctr_i && !pcm_i) begin
            wrap = (per_sh_ff == 16'h0000) ||
                   (dir_ff == EPWM_DOWN && cnt_ff == 16'h0000);
        end else begin
            wrap = (per_sh_ff == 16'h0000) ||
                   (cnt_ff >= per_sh_ff - 16'h0001);
        end
        if (!en_i) begin
            nxt_cnt = 16'h0000;
            nxt_dir = EPWM_UP;
            nxt_per_sh = per_i;
            nxt_duty_sh = duty_i;
        end else begin
            if (wrap) begin // see RULE_08
                nxt_per_sh = per_i;
                nxt_duty_sh = duty_i;
            end
            if (ctr_i && !pcm_i) begin // see RULE_05
                if (per_sh_ff == 16'h0000) begin
                    nxt_cnt = 16'h0000;
                    nxt_dir = EPWM_UP;
                end else if (dir_ff == EPWM_UP) begin
                    if (cnt_ff >= per_sh_ff) begin
                        nxt_dir = EPWM_DOWN;
                        nxt_cnt = cnt_ff - 16'h0001;
                    end else begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end else if (cnt_ff == 16'h0000) begin
                    nxt_dir = EPWM_UP;
                    nxt_cnt = 16'h0001;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end else begin // see RULE_01
                nxt_dir = EPWM_UP;
                nxt_cnt = wrap ? 16'h0000 : cnt_ff + 16'h0001;
            end
            if (pcm_i) begin // see RULE_03
                // Density of active cycles is duty over period
                if (duty_sh_ff >= per_sh_ff) begin
                    act = (duty_sh_ff != 16'h0000);
                end else begin
                    sum = {1'b0, acc_ff} + {1'b0, duty_sh_ff};
                    if (sum >= {1'b0, per_sh_ff}) begin
                        act = 1'b1;
                        nxt_acc = sum[15:0] - per_sh_ff;
                    end else begin
                        nxt_acc = sum[15:0];
                    end
                end
            end else begin
                act = (cnt_ff < duty_sh_ff); // see RULE_02
            end
        end
        nxt_out = pol_i ? act : !act; // see RULE_04
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 16'h0000;
            acc_ff <= 16'h0000;
            per_sh_ff <= 16'h0000;
            duty_sh_ff <= 16'h0000;
            dir_ff <= EPWM_UP;
            out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            acc_ff <= nxt_acc;
            per_sh_ff <= nxt_per_sh;
            duty_sh_ff <= nxt_duty_sh;
            dir_ff <= nxt_dir;
            out_ff <= nxt_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_left_wrap;
        @(posedge clk_i) disable iff (rst_i)
        en_i && !ctr_i && per_sh_ff != 16'h0000 &&
        cnt_ff == per_sh_ff - 16'h0001 |=> cnt_ff == 16'h0000;
    endproperty
    a_left_wrap: assert property (p_left_wrap) // see RULE_01
        else $error("left counter did not wrap at period");

    property p_zero_duty;
        @(posedge clk_i) disable iff (rst_i)
        en_i && !pcm_i && duty_sh_ff == 16'h0000 |=>
        pwm_o == !$past(pol_i);
    endproperty
    a_zero_duty: assert property (p_zero_duty) // see RULE_02
        else $error("zero duty output not inactive");

    property p_pcm_acc;
        @(posedge clk_i) disable iff (rst_i)
        en_i && pcm_i && !wrap && acc_ff < per_sh_ff |=>
        acc_ff < per_sh_ff;
    endproperty
    a_pcm_acc: assert property (p_pcm_acc) // see RULE_03
        else $error("density accumulator exceeded period");

    property p_full_duty;
        @(posedge clk_i) disable iff (rst_i)
        en_i && !pcm_i && !ctr_i && per_sh_ff != 16'h0000 &&
        duty_sh_ff >= per_sh_ff |=> pwm_o == $past(pol_i);
    endproperty
    a_full_duty: assert property (p_full_duty) // see RULE_04
        else $error("full duty output not at active level");

    property p_ctr_turn;
        @(posedge clk_i) disable iff (rst_i)
        en_i && ctr_i && !pcm_i && dir_ff == EPWM_UP &&
        per_sh_ff != 16'h0000 && cnt_ff == per_sh_ff |=>
        dir_ff == EPWM_DOWN && cnt_ff == $past(cnt_ff) - 16'h0001;
    endproperty
    a_ctr_turn: assert property (p_ctr_turn) // see RULE_05
        else $error("center counter did not turn at period");

    property p_shadow_hold;
        @(posedge clk_i) disable iff (rst_i)
        en_i && !wrap |=> $stable(per_sh_ff) && $stable(duty_sh_ff);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) // see RULE_08
        else $error("shadow changed inside a period");

    c_center_down: cover property (@(posedge clk_i) disable iff (rst_i)
        en_i && ctr_i && dir_ff == EPWM_DOWN);
    c_pcm_pulse: cover property (@(posedge clk_i) disable iff (rst_i)
        en_i && pcm_i && act && duty_sh_ff < per_sh_ff);

endmodule : epwm_chan

// *** testbench/epwm_top_bench.sv ***
// Self-checking bench for the eight channel PWM timer top.
// Assumes the register map of epwm_defs.svh and one clock at 125 MHz.
`timescale 1ns/1ps
`include "epwm_defs.svh"

module epwm_top_bench;
    import epwm_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    epwm_addr_t addr_i = 6'h00;
    epwm_byte_t wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    epwm_byte_t rdata_o;
    logic [7:0] pwm_o;
    int n_errors = 0;
    int check_count = 0;
    int hi [8];
    int tg [8];
    epwm_byte_t rv;
    epwm_byte_t rv2;

    epwm_top dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .we_i(we_i),
        .re_i(re_i),
        .rdata_o(rdata_o),
        .pwm_o(pwm_o)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task chk(input string what, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    task wr(input epwm_addr_t a, input epwm_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr

    task rd(input epwm_addr_t a, output epwm_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // Counts high samples and level changes of every pin over c cycles
    task measure(input int c);
        logic [7:0] prev;
        int k;
        for (k = 0; k < 8; k++) begin
            hi[k] = 0;
            tg[k] = 0;
        end
        #1;
        prev = pwm_o;
        repeat (c) begin
            @(posedge clk_i);
            #1;
            for (k = 0; k < 8; k++) begin
                if (pwm_o[k] === 1'b1) hi[k]++;
                if (pwm_o[k] !== prev[k]) tg[k]++;
            end
            prev = pwm_o;
        end
    endtask : measure

    task cfg(input epwm_byte_t pol, ctr, input logic [3:0] cat,
             input epwm_byte_t pcm);
        wr(`EPWM_A_ENABLE, 8'h00);
        wr(`EPWM_A_POL, pol);
        wr(`EPWM_A_CTR, ctr);
        wr(`EPWM_A_CAT, {4'h0, cat});
        wr(`EPWM_A_PCM, pcm);
    endtask : cfg

    task setch(input int n, input epwm_byte_t per, duty);
        wr({`EPWM_PG_PER, 3'(n)}, per);
        wr({`EPWM_PG_DUTY, 3'(n)}, duty);
    endtask : setch

    task run(input int c);
        wr(`EPWM_A_ENABLE, 8'hff);
        repeat (3) @(posedge clk_i);
        measure(c);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        epwm_addr_t ra [9];
        epwm_byte_t re [9];
        int i;
        ra = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h10, 6'h18, 6'h05};
        re = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("idle pins", 8'hff, pwm_o);
        for (i = 0; i < 9; i++) begin
            rd(ra[i], rv);
            chk("reset value", re[i], rv);
        end
        wr(6'h20, 8'h5a);
        rd(6'h20, rv);
        chk("unmapped", 8'h00, rv);
        wr(`EPWM_A_CAT, 8'hff);
        rd(`EPWM_A_CAT, rv);
        chk("join reg", 8'h0f, rv);
        @(posedge clk_i);
        #1;
        chk("rdata after", 8'h00, rdata_o);

        // Left aligned, full duty range on eight independent channels
        cfg(8'hff, 8'h00, 4'h0, 8'h00);
        for (i = 0; i < 8; i++) setch(i, 8'h08, (i == 7) ? 8'hff : 8'(i));
        run(16);
        for (i = 0; i < 8; i++) begin
            chk("left hi", (i == 7) ? 16 : 2 * i, hi[i]);
        end
        chk("left edges", 4, tg[4]);
        wr(`EPWM_A_POL, 8'h0f);
        repeat (2) @(posedge clk_i);
        measure(16);
        for (i = 4; i < 8; i++) begin
            chk("inverted hi", (i == 7) ? 0 : 16 - 2 * i,
                hi[i]);
        end

        // Center aligned
        cfg(8'hff, 8'hff, 4'h0, 8'h00);
        for (i = 0; i < 8; i++) setch(i, 8'h08, 8'(i));
        run(32);
        for (i = 0; i < 8; i++) begin
            chk("center hi", (i == 0) ? 0 : 4 * i - 2, hi[i]);
        end

        // Pulse density mode spreads the active cycles
        cfg(8'hff, 8'h00, 4'h0, 8'hff);
        run(16);
        for (i = 0; i < 8; i++) begin
            chk("density hi", 2 * i, hi[i]);
        end
        chk("density edges", 16, tg[4]);

        // Pairs 1:0 and 5:4 joined, others stay 8 bit
        cfg(8'hff, 8'h00, 4'h5, 8'h00);
        setch(0, 8'h00, 8'h40);
        setch(1, 8'h01, 8'h00);
        setch(4, 8'h00, 8'hc0);
        setch(5, 8'h01, 8'h00);
        run(512);
        chk("joined lo pin", 0, hi[0]);
        chk("joined 1", 128, hi[1]);
        chk("joined lo pin", 0, hi[4]);
        chk("joined 5", 384, hi[5]);
        chk("single 2", 128, hi[2]);
        chk("single 7", 448, hi[7]);

        // Duty change mid-period waits for the wrap
        cfg(8'hff, 8'h00, 4'h0, 8'h00);
        setch(0, 8'hc8, 8'h00);
        wr(`EPWM_A_ENABLE, 8'h01);
        wr({`EPWM_PG_DUTY, 3'h0}, 8'hc8);
        wr({`EPWM_PG_CNT, 3'h0}, 8'h00);
        rd({`EPWM_PG_CNT, 3'h0}, rv);
        rd({`EPWM_PG_CNT, 3'h0}, rv2);
        chk("counter read", 8'h05, rv);
        chk("counter step", 16'(rv) + 16'h2, 16'(rv2));
        measure(150);
        chk("held duty", 0, hi[0]);
        repeat (60) @(posedge clk_i);
        #1;
        chk("new duty", 1'b1, pwm_o[0]);
        end_sim();
    end
endmodule : epwm_top_bench
